// *** common/cts_pkg.sv ***
// Constants, field layout and duration lookups for the charger timer block
package cts_pkg;

  // Register offsets
  localparam logic [7:0] TIMER_CFG_ADDR = 8'h08;
  localparam logic [7:0] REF_EN_ADDR    = 8'h09;
  localparam logic [7:0] BSW_CFG_ADDR   = 8'h0a;

  // Timer configuration fields
  localparam int TERM_EN_BIT  = 7;
  localparam int ADC_EN_BIT   = 6;
  localparam int WDT_LSB      = 4;
  localparam int WDT_KICK_BIT = 3;
  localparam int CC_DUR_LSB   = 1;
  localparam int TMR_EN_BIT   = 0;

  // Reference enable field
  localparam int REF_N_BIT = 3;

  // Battery switch configuration fields
  localparam int FREQ_BIT      = 7;
  localparam int EXT_TMR_BIT   = 6;
  localparam int FORCE_OFF_BIT = 5;
  localparam int RST_SEL_BIT   = 4;
  localparam int OFF_DUR_LSB   = 2;
  localparam int HOLD_DUR_LSB  = 0;

  // Power-on values
  localparam logic [7:0] TIMER_CFG_RST = 8'h95;
  localparam logic [7:0] REF_EN_RST    = 8'h00;
  localparam logic [7:0] BSW_CFG_RST   = 8'h58;

  // Bits restored by a watchdog expiry and by a register reset, and the readable reference enable bits
  localparam logic [7:0] TIMER_WDT_MASK = 8'hcf;
  localparam logic [7:0] REF_WDT_MASK   = 8'h08;
  localparam logic [7:0] BSW_WDT_MASK   = 8'hcf;
  localparam logic [7:0] BSW_RRST_MASK  = 8'hdf;
  localparam logic [7:0] REF_RD_MASK    = 8'h08;

  // Timing base: every duration counts half-second ticks
  localparam int unsigned CLK_HZ          = 50_000_000;
  localparam int unsigned HALF_SEC_MS     = 500;
  localparam int unsigned HALF_SEC_CYCLES = CLK_HZ / 1000 * HALF_SEC_MS;
  localparam int unsigned HALVES_PER_S    = 2;
  localparam int unsigned S_PER_H         = 3600;

  localparam int unsigned WDT_A_S  = 40;
  localparam int unsigned WDT_B_S  = 80;
  localparam int unsigned WDT_C_S  = 160;
  localparam int unsigned CC_A_H   = 5;
  localparam int unsigned CC_B_H   = 8;
  localparam int unsigned CC_C_H   = 12;
  localparam int unsigned CC_D_H   = 20;
  localparam int unsigned OFF_A_MS = 500;
  localparam int unsigned OFF_B_S  = 2;
  localparam int unsigned OFF_C_S  = 4;
  localparam int unsigned OFF_D_S  = 8;
  localparam int unsigned HOLD_A_S = 8;
  localparam int unsigned HOLD_B_S = 10;
  localparam int unsigned HOLD_C_S = 12;
  localparam int unsigned HOLD_D_S = 16;

  localparam int CNT_W = 20;

  typedef enum logic [1:0] {
    CTS_IDLE = 2'b00,
    CTS_HOLD = 2'b01,
    CTS_OFF  = 2'b10,
    CTS_WAIT = 2'b11
  } cts_disconnect_pin_state_t;

  function automatic logic [CNT_W-1:0] wdt_halves(input logic [1:0] sel);
    case (sel)
      2'b01:   return CNT_W'(WDT_A_S * HALVES_PER_S);
      2'b10:   return CNT_W'(WDT_B_S * HALVES_PER_S);
      2'b11:   return CNT_W'(WDT_C_S * HALVES_PER_S);
      default: return '0;
    endcase
  endfunction : wdt_halves

  function automatic logic [CNT_W-1:0] cc_halves(input logic [1:0] sel);
    case (sel)
      2'b00:   return CNT_W'(CC_A_H * S_PER_H * HALVES_PER_S);
      2'b01:   return CNT_W'(CC_B_H * S_PER_H * HALVES_PER_S);
      2'b10:   return CNT_W'(CC_C_H * S_PER_H * HALVES_PER_S);
      default: return CNT_W'(CC_D_H * S_PER_H * HALVES_PER_S);
    endcase
  endfunction : cc_halves

  function automatic logic [CNT_W-1:0] off_halves(input logic [1:0] sel);
    case (sel)
      2'b00:   return CNT_W'(OFF_A_MS / HALF_SEC_MS);
      2'b01:   return CNT_W'(OFF_B_S * HALVES_PER_S);
      2'b10:   return CNT_W'(OFF_C_S * HALVES_PER_S);
      default: return CNT_W'(OFF_D_S * HALVES_PER_S);
    endcase
  endfunction : off_halves

  function automatic logic [CNT_W-1:0] hold_halves(input logic [1:0] sel);
    case (sel)
      2'b00:   return CNT_W'(HOLD_A_S * HALVES_PER_S);
      2'b01:   return CNT_W'(HOLD_B_S * HALVES_PER_S);
      2'b10:   return CNT_W'(HOLD_C_S * HALVES_PER_S);
      default: return CNT_W'(HOLD_D_S * HALVES_PER_S);
    endcase
  endfunction : hold_halves

endpackage : cts_pkg

// *** logic/cts_tick_gen.sv ***
// Divider that emits one-cycle half-second tick pulses
`timescale 1ns/1ps
module cts_tick_gen #(
  parameter int unsigned DIV = 25_000_000
) (
  input  wire logic mclk_i,
  input  wire logic rst_n_i,
  output logic      tick_o
);

  localparam int W = (DIV > 2) ? $clog2(DIV) : 1;
  localparam logic [W-1:0] LAST = W'(DIV - 1);

  logic [W-1:0] div_q;

  if (DIV < 2) begin : g_chk
    $error("cts_tick_gen: DIV must be at least 2");
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      div_q  <= '0;
      tick_o <= 1'b0;
    end else if (div_q == LAST) begin
      div_q  <= '0;
      tick_o <= 1'b1;
    end else begin
      div_q  <= div_q + 1'b1;
      tick_o <= 1'b0;
    end
  end

endmodule : cts_tick_gen

// *** logic/cts_tick_counter.sv ***
// Saturating counter of tick pulses with synchronous clear
`timescale 1ns/1ps
module cts_tick_counter #(
  parameter int W = 20
) (
  input  wire logic         mclk_i,
  input  wire logic         rst_n_i,
  input  wire logic         clr_i,
  input  wire logic         run_i,
  input  wire logic         tick_i,
  output logic [W-1:0]      count_o
);

  if (W < 2) begin : g_chk
    $error("cts_tick_counter: W must be at least 2");
  end

  // Saturates so a stalled comparison never wraps into a false match
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i || clr_i) begin
      count_o <= '0;
    end else if (run_i && tick_i && (count_o != '1)) begin
      count_o <= count_o + 1'b1;
    end
  end

endmodule : cts_tick_counter

// *** logic/cts_timer_ctrl.sv ***
// Timer and battery switch control registers with their sequencers
`timescale 1ns/1ps

// Notes on behaviour
// - Auto termination only while termination enable set
// - Standby ADC runs only when its bit set
// - Watchdog limit: off, 40s, 80s, 160s
// - Watchdog stopped whenever battery present
// - Kick bit restarts watchdog, then self-clears
// - Safety timer: 5, 8, 12, 20 hours
// - Safety timer runs only when enabled
// - Extended enable doubles safety timer duration
// - Reference enable falling restarts detection, safety timer
// - Force-off bit holds switch off, survives register reset and watchdog expiry, cleared by rst_n_i
// - Pin held low: switch off, wait, on
// - Off time: 0.5s, 2s, 4s, 8s
// - Pin hold time: 8s, 10s, 12s, 16s
module cts_timer_ctrl #(
  parameter int unsigned HALF_SEC_CYCLES = cts_pkg::HALF_SEC_CYCLES,
  parameter int          CNT_W           = cts_pkg::CNT_W
) (
  input  wire logic       mclk_i,
  input  wire logic       rst_n_i,
  input  wire logic [7:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  output logic      [7:0] reg_rdata_o,
  input  wire logic       reg_rst_i,
  input  wire logic       battery_present_i,
  input  wire logic       termination_reached_i,
  input  wire logic       cc_charging_i,
  input  wire logic       disconnect_pin_i,
  output logic            charge_terminate_o,
  output logic            standby_adc_enable_o,
  output logic            watchdog_expiry_o,
  output logic            safety_timer_fault_o,
  output logic            plug_detect_restart_o,
  output logic            reference_enable_n_o,
  output logic            switching_frequency_select_o,
  output logic            reset_type_select_o,
  output logic            battery_switch_o
);

  if (CNT_W < 19) begin : g_chk
    $error("cts_timer_ctrl: CNT_W too narrow for the longest timer");
  end

  logic [7:0]       timer_cfg_q;
  logic             ref_n_q;
  logic             ref_n_d;
  logic [7:0]       bsw_cfg_q;
  logic             tick;
  logic             wdt_active;
  logic             wdt_clr;
  logic             wdt_expire;
  logic [CNT_W-1:0] wdt_cnt;
  logic [CNT_W-1:0] wdt_limit;
  logic             ref_fall;
  logic             safety_run;
  logic             safety_clr;
  logic             safety_done;
  logic [CNT_W-1:0] safety_cnt;
  logic [CNT_W-1:0] safety_limit;
  logic             disconnect_pin_clr;
  logic [CNT_W-1:0] disconnect_pin_cnt;
  logic [CNT_W-1:0] hold_limit;
  logic [CNT_W-1:0] off_limit;
  logic             pin_low;
  logic             wr_timer;
  logic             wr_ref;
  logic             wr_bsw;

  cts_pkg::cts_disconnect_pin_state_t disconnect_pin_q;
  cts_pkg::cts_disconnect_pin_state_t disconnect_pin_d;

  assign wr_timer = reg_wr_i && (reg_addr_i == cts_pkg::TIMER_CFG_ADDR);
  assign wr_ref   = reg_wr_i && (reg_addr_i == cts_pkg::REF_EN_ADDR);
  assign wr_bsw   = reg_wr_i && (reg_addr_i == cts_pkg::BSW_CFG_ADDR);
  assign pin_low  = !disconnect_pin_i;

  cts_tick_gen #(
    .DIV (HALF_SEC_CYCLES)
  ) u_tick (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    .tick_o  (tick)
  );

  // Timer configuration register
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      timer_cfg_q <= cts_pkg::TIMER_CFG_RST;
    end else if (reg_rst_i) begin
      timer_cfg_q <= cts_pkg::TIMER_CFG_RST;
    end else if (wdt_expire) begin
      timer_cfg_q <= (timer_cfg_q & ~cts_pkg::TIMER_WDT_MASK)
                   | (cts_pkg::TIMER_CFG_RST & cts_pkg::TIMER_WDT_MASK);
    end else if (wr_timer) begin
      timer_cfg_q <= reg_wdata_i;
    end else if (timer_cfg_q[cts_pkg::WDT_KICK_BIT]) begin
      timer_cfg_q[cts_pkg::WDT_KICK_BIT] <= 1'b0;
    end
  end

  // Reference enable, active low
  always_comb begin
    ref_n_d = ref_n_q;
    if (reg_rst_i) begin
      ref_n_d = cts_pkg::REF_EN_RST[cts_pkg::REF_N_BIT];
    end else if (wdt_expire) begin
      ref_n_d = cts_pkg::REF_EN_RST[cts_pkg::REF_N_BIT];
    end else if (wr_ref) begin
      ref_n_d = reg_wdata_i[cts_pkg::REF_N_BIT];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      ref_n_q <= cts_pkg::REF_EN_RST[cts_pkg::REF_N_BIT];
    end else begin
      ref_n_q <= ref_n_d;
    end
  end

  assign ref_fall = ref_n_q && !ref_n_d;

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      plug_detect_restart_o <= 1'b0;
    end else begin
      plug_detect_restart_o <= ref_fall;
    end
  end

  // Battery switch configuration register
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      bsw_cfg_q <= cts_pkg::BSW_CFG_RST;
    end else if (reg_rst_i) begin
      bsw_cfg_q <= (bsw_cfg_q & ~cts_pkg::BSW_RRST_MASK)
                 | (cts_pkg::BSW_CFG_RST & cts_pkg::BSW_RRST_MASK);
    end else if (wdt_expire) begin
      bsw_cfg_q <= (bsw_cfg_q & ~cts_pkg::BSW_WDT_MASK)
                 | (cts_pkg::BSW_CFG_RST & cts_pkg::BSW_WDT_MASK);
    end else if (wr_bsw) begin
      bsw_cfg_q <= reg_wdata_i;
    end
  end

  // Readback, unmapped offsets read zero
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      if (reg_addr_i == cts_pkg::TIMER_CFG_ADDR) begin
        reg_rdata_o <= timer_cfg_q;
      end else if (reg_addr_i == cts_pkg::REF_EN_ADDR) begin
        reg_rdata_o <= {4'h0, ref_n_q, 3'h0} & cts_pkg::REF_RD_MASK;
      end else if (reg_addr_i == cts_pkg::BSW_CFG_ADDR) begin
        reg_rdata_o <= bsw_cfg_q;
      end else begin
        reg_rdata_o <= 8'h00;
      end
    end
  end

  assign wdt_limit = cts_pkg::wdt_halves(
                       timer_cfg_q[cts_pkg::WDT_LSB +: 2]);
  assign wdt_active = (wdt_limit != '0) && !battery_present_i;
  assign wdt_expire = wdt_active && (wdt_cnt >= wdt_limit);
  assign wdt_clr = !wdt_active || wdt_expire
                 || timer_cfg_q[cts_pkg::WDT_KICK_BIT];

  cts_tick_counter #(
    .W (CNT_W)
  ) u_wdt_cnt (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    .clr_i   (wdt_clr),
    .run_i   (wdt_active),
    .tick_i  (tick),
    .count_o (wdt_cnt)
  );

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      watchdog_expiry_o <= 1'b0;
    end else begin
      watchdog_expiry_o <= wdt_expire;
    end
  end

  assign safety_limit = bsw_cfg_q[cts_pkg::EXT_TMR_BIT]
    ? CNT_W'({cts_pkg::cc_halves(timer_cfg_q[cts_pkg::CC_DUR_LSB +: 2]),
              1'b0})
    : cts_pkg::cc_halves(timer_cfg_q[cts_pkg::CC_DUR_LSB +: 2]);
  assign safety_run  = timer_cfg_q[cts_pkg::TMR_EN_BIT] && cc_charging_i;
  assign safety_clr  = !safety_run || ref_fall;
  assign safety_done = safety_run && (safety_cnt >= safety_limit);

  cts_tick_counter #(
    .W (CNT_W)
  ) u_safety_cnt (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    .clr_i   (safety_clr),
    .run_i   (safety_run),
    .tick_i  (tick),
    .count_o (safety_cnt)
  );

  // Fault set wins over a clear in the same cycle
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      safety_timer_fault_o <= 1'b0;
    end else if (safety_done) begin
      safety_timer_fault_o <= 1'b1;
    end else if (safety_clr) begin
      safety_timer_fault_o <= 1'b0;
    end
  end

  assign hold_limit = cts_pkg::hold_halves(
                        bsw_cfg_q[cts_pkg::HOLD_DUR_LSB +: 2]);
  assign off_limit  = cts_pkg::off_halves(
                        bsw_cfg_q[cts_pkg::OFF_DUR_LSB +: 2]);

  // hold, off, back on; wait for release to avoid a repeat
  always_comb begin
    disconnect_pin_d = disconnect_pin_q;
    case (disconnect_pin_q)
      cts_pkg::CTS_IDLE: begin
        if (pin_low) begin
          disconnect_pin_d = cts_pkg::CTS_HOLD;
        end
      end
      cts_pkg::CTS_HOLD: begin
        if (!pin_low) begin
          disconnect_pin_d = cts_pkg::CTS_IDLE;
        end else if (disconnect_pin_cnt >= hold_limit) begin
          disconnect_pin_d = cts_pkg::CTS_OFF;
        end
      end
      cts_pkg::CTS_OFF: begin
        if (disconnect_pin_cnt >= off_limit) begin
          disconnect_pin_d = cts_pkg::CTS_WAIT;
        end
      end
      cts_pkg::CTS_WAIT: begin
        if (!pin_low) begin
          disconnect_pin_d = cts_pkg::CTS_IDLE;
        end
      end
      default: begin
        disconnect_pin_d = cts_pkg::CTS_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      disconnect_pin_q <= cts_pkg::CTS_IDLE;
    end else begin
      disconnect_pin_q <= disconnect_pin_d;
    end
  end

  assign disconnect_pin_clr = (disconnect_pin_q != disconnect_pin_d) || (disconnect_pin_q == cts_pkg::CTS_IDLE);

  cts_tick_counter #(
    .W (CNT_W)
  ) u_disconnect_pin_cnt (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    .clr_i   (disconnect_pin_clr),
    .run_i   (1'b1),
    .tick_i  (tick),
    .count_o (disconnect_pin_cnt)
  );

  // force-off overrides, off during the off phase
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      battery_switch_o <= 1'b0;
    end else begin
      battery_switch_o <= !bsw_cfg_q[cts_pkg::FORCE_OFF_BIT]
                       && (disconnect_pin_d != cts_pkg::CTS_OFF);
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      charge_terminate_o <= 1'b0;
    end else begin
      charge_terminate_o <= termination_reached_i
                         && timer_cfg_q[cts_pkg::TERM_EN_BIT];
    end
  end

  assign standby_adc_enable_o = timer_cfg_q[cts_pkg::ADC_EN_BIT];

  assign reference_enable_n_o         = ref_n_q;
  assign switching_frequency_select_o = bsw_cfg_q[cts_pkg::FREQ_BIT];
  assign reset_type_select_o          = bsw_cfg_q[cts_pkg::RST_SEL_BIT];

endmodule : cts_timer_ctrl

// *** verif/cts_timer_ctrl_props.sv ***
// Assertion checker for the timer control ports
`timescale 1ns/1ps
module cts_timer_ctrl_props #(
  parameter int unsigned HALF_SEC_CYCLES = 4
) (
  input wire logic       mclk_i,
  input wire logic       rst_n_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic       reg_wr_i,
  input wire logic       reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic       reg_rst_i,
  input wire logic       battery_present_i,
  input wire logic       termination_reached_i,
  input wire logic       disconnect_pin_i,
  input wire logic       charge_terminate_o,
  input wire logic       standby_adc_enable_o,
  input wire logic       watchdog_expiry_o,
  input wire logic       plug_detect_restart_o,
  input wire logic       reference_enable_n_o,
  input wire logic       battery_switch_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  // Bounds below assume a tick every 4 cycles
  sequence off_start_s;
    !disconnect_pin_i && $fell(battery_switch_o);
  endsequence

  sequence wr_s(logic [7:0] a);
    reg_wr_i && reg_addr_i == a && !reg_rst_i;
  endsequence

  term_gate_a: assert property (
    charge_terminate_o |-> $past(termination_reached_i))
    else $error("terminate without cause");
  adc_write_a: assert property (
    wr_s(8'h08) |=> standby_adc_enable_o == $past(reg_wdata_i[6]))
    else $error("standby adc enable wrong");
  wdt_pulse_a: assert property (
    watchdog_expiry_o |=> !watchdog_expiry_o)
    else $error("expiry pulse too long");
  wdt_battery_a: assert property (
    battery_present_i [*3] |-> !watchdog_expiry_o)
    else $error("expiry with battery present");
  plug_fall_a: assert property (
    plug_detect_restart_o |->
      !reference_enable_n_o && $past(reference_enable_n_o))
    else $error("restart pulse without fall");
  ref_read_a: assert property (
    reg_rd_i && reg_addr_i == 8'h09 |=> (reg_rdata_o & 8'hf7) == 8'h00)
    else $error("reserved bits read nonzero");
  force_off_a: assert property (
    wr_s(8'h0a) and reg_wdata_i[5] |-> ##2 !battery_switch_o)
    else $error("switch on while forced off");
  hold_min_a: assert property (
    $fell(disconnect_pin_i) && battery_switch_o |=> battery_switch_o [*8])
    else $error("switch off before hold time");
  off_span_a: assert property (
    off_start_s |=> !battery_switch_o [*8] ##[1:40] battery_switch_o)
    else $error("off time out of range");
endmodule : cts_timer_ctrl_props

// *** verif/cts_disconnect_pin_model.sv ***
// Outside driver model of the disconnect pin
`timescale 1ns/1ps
module cts_disconnect_pin_model (
  input  wire logic        mclk_i,
  input  wire logic        rst_n_i,
  input  wire logic        start_i,
  input  wire logic [15:0] len_i,
  output logic             disconnect_pin_o
);
  logic [15:0] left_q;

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      left_q <= 16'h0000;
    end else if (start_i) begin
      left_q <= len_i;
    end else if (left_q != 16'h0000) begin
      left_q <= left_q - 16'h0001;
    end
  end

  // Pin has a pull-up, so released means high
  assign disconnect_pin_o = (left_q == 16'h0000);
endmodule : cts_disconnect_pin_model

// *** verif/tb_top.sv ***
// Self-checking bench for the timer control block
`timescale 1ns/1ps
module tb_top;
  logic        mclk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic [7:0]  reg_addr_i = 8'h00;
  logic [7:0]  reg_wdata_i = 8'h00;
  logic        reg_wr_i = 1'b0;
  logic        reg_rd_i = 1'b0;
  logic        reg_rst_i = 1'b0;
  logic        battery_present_i = 1'b1;
  logic        termination_reached_i = 1'b0;
  logic        cc_charging_i = 1'b1;
  logic        start_q = 1'b0;
  logic [15:0] len_q = 16'h0000;
  logic        disconnect_pin_i;
  logic [7:0]  reg_rdata_o;
  logic        charge_terminate_o, standby_adc_enable_o;
  logic        watchdog_expiry_o, safety_timer_fault_o;
  logic        plug_detect_restart_o, reference_enable_n_o;
  logic        switching_frequency_select_o, reset_type_select_o;
  logic        battery_switch_o;
  int          failures = 0;
  int          checks_done = 0;
  int          n;

  initial forever #10 mclk_i = ~mclk_i;

  cts_timer_ctrl #(.HALF_SEC_CYCLES(4)) cts_timer_ctrl_i (
    .mclk_i, .rst_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
    .reg_rdata_o, .reg_rst_i, .battery_present_i, .termination_reached_i,
    .cc_charging_i, .disconnect_pin_i, .charge_terminate_o,
    .standby_adc_enable_o, .watchdog_expiry_o, .safety_timer_fault_o,
    .plug_detect_restart_o, .reference_enable_n_o,
    .switching_frequency_select_o, .reset_type_select_o, .battery_switch_o);

  cts_disconnect_pin_model cts_disconnect_pin_model_i (.mclk_i, .rst_n_i, .start_i(start_q),
    .len_i(len_q), .disconnect_pin_o(disconnect_pin_i));

  task automatic stop_test();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : stop_test

  task automatic chk8(input string nm, input logic [7:0] e, g);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk8

  task automatic chk1(input string nm, input logic e, g);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %b seen %b", nm, e, g);
    end
  endtask : chk1

  task automatic cyc(input int k);
    repeat (k) @(posedge mclk_i);
    #1;
  endtask : cyc

  // Idle cycle at the end keeps strobes apart
  task automatic wr(input logic [7:0] a, d);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    cyc(1);
    reg_wr_i = 1'b0;
    cyc(1);
  endtask : wr

  task automatic rd(input logic [7:0] a, e);
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    cyc(1);
    reg_rd_i = 1'b0;
    chk8("reg_rdata_o", e, reg_rdata_o);
    cyc(1);
  endtask : rd

  task automatic pull(input logic [15:0] k);
    len_q = k;
    start_q = 1'b1;
    cyc(1);
    start_q = 1'b0;
  endtask : pull

  initial begin
    #200000;
    failures++;
    stop_test();
  end

  initial begin
    cyc(6);
    rst_n_i = 1'b1;
    cyc(1);
    chk1("battery_switch_o", 1'b1, battery_switch_o);
    rd(8'h08, 8'h95);
    rd(8'h09, 8'h00);
    rd(8'h0a, 8'h58);
    chk1("standby_adc_enable_o", 1'b0, standby_adc_enable_o);
    chk1("reset_type_select_o", 1'b1, reset_type_select_o);
    $display("test reset_values done");
    wr(8'h08, 8'hd5);
    chk1("standby_adc_enable_o", 1'b1, standby_adc_enable_o);
    wr(8'h0a, 8'hbf);
    chk1("battery_switch_o", 1'b0, battery_switch_o);
    chk1("switching_frequency_select_o", 1'b1,
         switching_frequency_select_o);
    wr(8'h0b, 8'hff);
    rd(8'h0b, 8'h00);
    rd(8'h0a, 8'hbf);
    wr(8'h09, 8'hff);
    rd(8'h09, 8'h08);
    chk1("reference_enable_n_o", 1'b1, reference_enable_n_o);
    // Pulse stands one cycle after the write edge only
    reg_addr_i = 8'h09;
    reg_wdata_i = 8'h00;
    reg_wr_i = 1'b1;
    cyc(1);
    reg_wr_i = 1'b0;
    chk1("plug_detect_restart_o", 1'b1, plug_detect_restart_o);
    chk1("reference_enable_n_o", 1'b0, reference_enable_n_o);
    cyc(1);
    chk1("plug_detect_restart_o", 1'b0, plug_detect_restart_o);
    $display("test register_writes done");
    reg_rst_i = 1'b1;
    cyc(1);
    reg_rst_i = 1'b0;
    cyc(1);
    rd(8'h08, 8'h95);
    rd(8'h0a, 8'h78);
    wr(8'h0a, 8'h58);
    cyc(1);
    chk1("battery_switch_o", 1'b1, battery_switch_o);
    wr(8'h08, 8'h9d);
    rd(8'h08, 8'h95);
    termination_reached_i = 1'b1;
    cyc(2);
    chk1("charge_terminate_o", 1'b1, charge_terminate_o);
    wr(8'h08, 8'h15);
    cyc(1);
    chk1("charge_terminate_o", 1'b0, charge_terminate_o);
    termination_reached_i = 1'b0;
    $display("test reset_and_kick done");
    // Battery present, then limit off: no expiry either way
    n = 0;
    repeat (400) begin
      cyc(1);
      if (watchdog_expiry_o !== 1'b0) n++;
    end
    chk1("watchdog_quiet", 1'b0, logic'(n != 0));
    wr(8'h08, 8'h85);
    battery_present_i = 1'b0;
    n = 0;
    repeat (400) begin
      cyc(1);
      if (watchdog_expiry_o !== 1'b0) n++;
    end
    chk1("watchdog_quiet", 1'b0, logic'(n != 0));
    wr(8'h08, 8'hdd);
    wr(8'h0a, 8'h0c);
    n = 0;
    while (watchdog_expiry_o !== 1'b1 && n < 400) begin
      cyc(1);
      n++;
    end
    battery_present_i = 1'b1;
    chk1("watchdog_expiry_o", 1'b1, watchdog_expiry_o);
    chk1("expiry_time", 1'b1, logic'(n >= 300 && n <= 330));
    rd(8'h08, 8'h95);
    rd(8'h0a, 8'h48);
    $display("test watchdog done");
    pull(16'd200);
    n = 0;
    while (battery_switch_o === 1'b1 && n < 100) begin
      cyc(1);
      n++;
    end
    chk1("hold_time", 1'b1, logic'(n >= 58 && n <= 70));
    n = 0;
    while (battery_switch_o !== 1'b1 && n < 60) begin
      cyc(1);
      n++;
    end
    chk1("off_time", 1'b1, logic'(n >= 26 && n <= 36));
    chk1("disconnect_pin_i", 1'b0, disconnect_pin_i);
    cyc(120);
    pull(16'd40);
    n = 0;
    repeat (120) begin
      cyc(1);
      if (battery_switch_o !== 1'b1) n++;
    end
    chk1("hold_abort", 1'b0, logic'(n != 0));
    // Longest hold with a short off time
    wr(8'h0a, 8'h47);
    pull(16'd200);
    n = 0;
    while (battery_switch_o === 1'b1 && n < 200) begin
      cyc(1);
      n++;
    end
    chk1("hold_time", 1'b1, logic'(n >= 122 && n <= 133));
    n = 0;
    while (battery_switch_o !== 1'b1 && n < 60) begin
      cyc(1);
      n++;
    end
    chk1("off_time", 1'b1, logic'(n >= 10 && n <= 20));
    chk1("safety_timer_fault_o", 1'b0, safety_timer_fault_o);
    $display("test disconnect done");
    stop_test();
  end
endmodule : tb_top

bind cts_timer_ctrl cts_timer_ctrl_props #(
  .HALF_SEC_CYCLES(HALF_SEC_CYCLES)
) cts_timer_ctrl_props_i (
  .mclk_i, .rst_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
  .reg_rdata_o, .reg_rst_i, .battery_present_i, .termination_reached_i,
  .disconnect_pin_i, .charge_terminate_o, .standby_adc_enable_o,
  .watchdog_expiry_o, .plug_detect_restart_o, .reference_enable_n_o,
  .battery_switch_o);
